// file: crt_pkg.sv
// Purpose: shared constants and types of the raster timing controller
// Assumes: one 250 MHz clock; character rate is an enable pulse
// Notes: register indices follow the documented numbering
package crt_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int CHAR_PERIOD_NS = 200;
  // least time: round up to whole clock cycles
  localparam int CHAR_CYCLES = (CHAR_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] CHAR_LAST = DIV_W'(CHAR_CYCLES - 1);

  localparam int ADDR_W = 14;
  localparam int HI_W = ADDR_W - 8;
  localparam int RAS_W = 5;

  localparam logic [4:0] IDX_HTOTAL = 5'h00;
  localparam logic [4:0] IDX_HDISP = 5'h01;
  localparam logic [4:0] IDX_HSYNC_POS = 5'h02;
  localparam logic [4:0] IDX_SYNC_WIDTH = 5'h03;
  localparam logic [4:0] IDX_VTOTAL = 5'h04;
  localparam logic [4:0] IDX_VADJ = 5'h05;
  localparam logic [4:0] IDX_VDISP = 5'h06;
  localparam logic [4:0] IDX_VSYNC_POS = 5'h07;
  localparam logic [4:0] IDX_MODE_SKEW = 5'h08;
  localparam logic [4:0] IDX_MAX_RASTER = 5'h09;
  localparam logic [4:0] IDX_CUR_FIRST = 5'h0a;
  localparam logic [4:0] IDX_CUR_LAST = 5'h0b;
  localparam logic [4:0] IDX_START_HI = 5'h0c;
  localparam logic [4:0] IDX_START_LO = 5'h0d;
  localparam logic [4:0] IDX_CUR_HI = 5'h0e;
  localparam logic [4:0] IDX_CUR_LO = 5'h0f;
  localparam logic [4:0] IDX_PEN_HI = 5'h10;
  localparam logic [4:0] IDX_PEN_LO = 5'h11;

  localparam logic [7:0] REG_RESET = 8'h00;

  // field positions
  localparam int SCAN_LSB = 0;
  localparam int DE_SKEW_LSB = 4;
  localparam int CUR_SKEW_LSB = 6;
  localparam int BLINK_LSB = 5;
  localparam int VSW_LSB = 4;

  localparam logic [1:0] SCAN_ISV = 2'h3;
  localparam logic [1:0] SKEW_NONE = 2'h0;
  localparam logic [1:0] SKEW_ONE = 2'h1;
  localparam logic [1:0] SKEW_TWO = 2'h2;
  localparam logic [1:0] SKEW_OFF = 2'h3;
  localparam logic [1:0] CUR_STEADY = 2'h0;
  localparam logic [1:0] CUR_HIDDEN = 2'h1;
  localparam logic [1:0] CUR_BLINK16 = 2'h2;
  localparam logic [1:0] CUR_BLINK32 = 2'h3;
  localparam int BLINK16_BIT = 4;
  localparam int BLINK32_BIT = 5;
  localparam logic [4:0] VSW_ZERO_RASTERS = 5'h10;

  typedef enum logic [0:0] {VP_ROWS, VP_ADJ} crt_vphase_t;

  function automatic logic [ADDR_W-1:0] crt_add(input logic [ADDR_W-1:0] a,
                                                 input logic [7:0] b);
    crt_add = a + {{(ADDR_W-8){1'b0}}, b};
  endfunction : crt_add

endpackage : crt_pkg

// file: crt_sync2.sv
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: each bit is independent
// Notes: first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module crt_sync2 #(parameter int W = 1) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : crt_sync2
`default_nettype wire

// file: crt_skew.sv
// Purpose: character-rate delay of zero, one or two characters, or off
// Assumes: adv is the one-cycle character enable
// Notes: output is registered in every setting
`timescale 1ns/1ps
`default_nettype none
module crt_skew import crt_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic adv,
  input wire logic d,
  input wire logic [1:0] sel,
  output logic q
);
  logic d1;
  logic d2;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      d1 <= 1'b0;
      d2 <= 1'b0;
      q <= 1'b0;
    end else if (adv) begin
      d1 <= d;
      d2 <= d1;
      case (sel)
        SKEW_NONE: q <= d;
        SKEW_ONE: q <= d1;
        SKEW_TWO: q <= d2;
        default: q <= 1'b0;
      endcase
    end
  end
endmodule : crt_skew
`default_nettype wire

// file: crt_timing_top.sv
// Purpose: character raster timing generator with indexed host registers
// Assumes: host bus pins and pen strobe are asynchronous to mclk
// Notes: character clock is an enable every CHAR_CYCLES mclk cycles
//
// What this block does
// - horizontal sync width 1..15 characters; zero must not be programmed
// - mode bits 5:4 delay display enable by 0, 1, 2 characters or suppress
// - mode bits 7:6 delay cursor the same way; value 3 stops cursor
// - mode bits 1:0 pick scan mode; bits 3:2 are ignored
// - raster counter wraps to zero after the maximum raster value; in interlace video mode once row select reaches that value less one
// - cursor shows from the first-line raster of the row
// - cursor modes steady, hidden, blink every 16 or every 32 fields
// - cursor shown up to the last-line raster of the row
// - start address loads each frame; high two bits read zero
// - cursor position readable and writable; high two bits zero
// - pen capture read-only; high two bits read zero
// - odd interlaced field shifts vertical sync by half a raster
// - interlace video mode alternates row-select parity by field, and by row for odd rasters per row
// - raster lasts total plus one characters, enable over displayed count
// - row address starts at start address plus row times displayed count, steps per character
// - vertical sync width in rasters from upper nibble; zero means 16
// - pen strobe rising edge latches the refresh address
`timescale 1ns/1ps
`default_nettype none
module crt_timing_top import crt_pkg::*; (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic bus_cs_n,
  input wire logic bus_rs,
  input wire logic bus_rw,
  input wire logic bus_en,
  input wire logic [7:0] bus_d_in,
  output logic [7:0] bus_d_out,
  output logic bus_d_oe,
  input wire logic pen_strobe_in,
  output logic hsync_out,
  output logic vsync_out,
  output logic display_enable_out,
  output logic cursor_out,
  output logic [ADDR_W-1:0] refresh_address_out,
  output logic [RAS_W-1:0] row_select_out
);

  ////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  logic cs_n_s;
  logic rs_s;
  logic rw_s;
  logic en_s;
  logic pen_s;
  logic [7:0] d_s;
  crt_sync2 #(.W(13)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d({bus_cs_n, bus_rs, bus_rw, bus_en, pen_strobe_in, bus_d_in}),
    .q({cs_n_s, rs_s, rw_s, en_s, pen_s, d_s})
  );

  ////////////////////////////////////////////////////////////////////////
  // host register file
  logic en_q;
  logic pen_q;
  logic [4:0] reg_index;
  logic [7:0] htotal, hdisp, hsync_pos, sync_width, mode_skew;
  logic [6:0] vtotal, vdisp, vsync_pos, cur_first;
  logic [4:0] vadj, max_raster, cur_last;
  logic [HI_W-1:0] start_hi, cur_hi, pen_hi;
  logic [7:0] start_lo, cur_lo, pen_lo;
  logic [7:0] rd_mux;
  logic wr_ev;
  logic pen_rise;
  logic [ADDR_W-1:0] ma;

  // data is sampled when the enable is seen falling, inside its hold time
  assign wr_ev = en_q & ~en_s & ~cs_n_s & ~rw_s;
  assign pen_rise = pen_s & ~pen_q;
  assign bus_d_oe = en_s & ~cs_n_s & rw_s;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b0;
      pen_q <= 1'b0;
    end else begin
      en_q <= en_s;
      pen_q <= pen_s;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) reg_index <= 5'h00;
    else if (wr_ev && !rs_s) reg_index <= d_s[4:0];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      htotal <= REG_RESET; hdisp <= REG_RESET; hsync_pos <= REG_RESET;
      sync_width <= REG_RESET; mode_skew <= REG_RESET;
      vtotal <= REG_RESET[6:0]; vdisp <= REG_RESET[6:0];
      vsync_pos <= REG_RESET[6:0]; cur_first <= REG_RESET[6:0];
      vadj <= REG_RESET[4:0]; max_raster <= REG_RESET[4:0];
      cur_last <= REG_RESET[4:0];
      start_hi <= REG_RESET[HI_W-1:0]; start_lo <= REG_RESET;
      cur_hi <= REG_RESET[HI_W-1:0]; cur_lo <= REG_RESET;
    end else if (wr_ev && rs_s) begin
      case (reg_index)
        IDX_HTOTAL: htotal <= d_s;
        IDX_HDISP: hdisp <= d_s;
        IDX_HSYNC_POS: hsync_pos <= d_s;
        IDX_SYNC_WIDTH: sync_width <= d_s;
        IDX_VTOTAL: vtotal <= d_s[6:0];
        IDX_VADJ: vadj <= d_s[4:0];
        IDX_VDISP: vdisp <= d_s[6:0];
        IDX_VSYNC_POS: vsync_pos <= d_s[6:0];
        IDX_MODE_SKEW: mode_skew <= d_s;
        IDX_MAX_RASTER: max_raster <= d_s[4:0];
        IDX_CUR_FIRST: cur_first <= d_s[6:0];
        IDX_CUR_LAST: cur_last <= d_s[4:0];
        IDX_START_HI: start_hi <= d_s[HI_W-1:0];
        IDX_START_LO: start_lo <= d_s;
        IDX_CUR_HI: cur_hi <= d_s[HI_W-1:0];
        IDX_CUR_LO: cur_lo <= d_s;
        default: ; // pen capture and unused indices take no write
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pen_hi <= REG_RESET[HI_W-1:0];
      pen_lo <= REG_RESET;
    end else if (pen_rise) begin
      {pen_hi, pen_lo} <= ma;
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    case (reg_index)
      IDX_HTOTAL: rd_mux = htotal;
      IDX_HDISP: rd_mux = hdisp;
      IDX_HSYNC_POS: rd_mux = hsync_pos;
      IDX_SYNC_WIDTH: rd_mux = sync_width;
      IDX_VTOTAL: rd_mux = {1'b0, vtotal};
      IDX_VADJ: rd_mux = {3'h0, vadj};
      IDX_VDISP: rd_mux = {1'b0, vdisp};
      IDX_VSYNC_POS: rd_mux = {1'b0, vsync_pos};
      IDX_MODE_SKEW: rd_mux = mode_skew;
      IDX_MAX_RASTER: rd_mux = {3'h0, max_raster};
      IDX_CUR_FIRST: rd_mux = {1'b0, cur_first};
      IDX_CUR_LAST: rd_mux = {3'h0, cur_last};
      IDX_START_HI: rd_mux = {2'h0, start_hi};
      IDX_START_LO: rd_mux = start_lo;
      IDX_CUR_HI: rd_mux = {2'h0, cur_hi};
      IDX_CUR_LO: rd_mux = cur_lo;
      IDX_PEN_HI: rd_mux = {2'h0, pen_hi};
      IDX_PEN_LO: rd_mux = pen_lo;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) bus_d_out <= 8'h00;
    else if (bus_d_oe) bus_d_out <= rs_s ? rd_mux : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // character enable and horizontal timing
  logic [DIV_W-1:0] div_cnt;
  logic char_en;
  logic [7:0] hcnt;
  logic [3:0] hs_left;
  logic line_end;
  logic line_tick;
  logic half_pt;

  assign char_en = (div_cnt == CHAR_LAST);
  assign line_end = (hcnt == htotal);
  assign line_tick = char_en & line_end;
  // half of total plus one characters, a true half raster for odd totals
  assign half_pt = ({1'b0, hcnt} == (({1'b0, htotal} + 9'h001) >> 1));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) div_cnt <= '0;
    else div_cnt <= char_en ? '0 : div_cnt + 1'b1;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) hcnt <= 8'h00;
    else if (char_en) hcnt <= line_end ? 8'h00 : hcnt + 8'h01;
  end

  // zero width is not legal; it would give sixteen characters here
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hs_left <= 4'h0;
      hsync_out <= 1'b0;
    end else if (char_en) begin
      if (hcnt == hsync_pos) begin
        hs_left <= sync_width[3:0] - 4'h1;
        hsync_out <= 1'b1;
      end else if (hs_left != 4'h0) begin
        hs_left <= hs_left - 4'h1;
      end else begin
        hsync_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // vertical timing, fields and row addressing
  crt_vphase_t vphase;
  logic [4:0] rcnt, adj_cnt;
  logic [6:0] row;
  logic field;
  logic [5:0] blink_cnt;
  logic [ADDR_W-1:0] row_base;
  logic isv, ilace, par, row_last, frame_done;
  logic [RAS_W-1:0] ra;

  assign ilace = mode_skew[SCAN_LSB];
  assign isv = (mode_skew[SCAN_LSB+1:SCAN_LSB] == SCAN_ISV);
  // odd rasters per row swap parity on odd rows for a steadier image
  assign par = field ^ (~max_raster[0] & row[0]);
  assign ra = (vphase == VP_ADJ) ? adj_cnt : (isv ? {rcnt[3:0], par} : rcnt);
  assign row_last = isv ? (({1'b0, ra} + 6'h02) > {1'b0, max_raster})
                        : (rcnt == max_raster);
  assign frame_done = (vphase == VP_ADJ) ? ((adj_cnt + 5'h01) == vadj)
                    : (row_last && row == vtotal && vadj == 5'h00);
  assign ma = crt_add(row_base, hcnt);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vphase <= VP_ROWS;
      rcnt <= 5'h00;
      adj_cnt <= 5'h00;
      row <= 7'h00;
      field <= 1'b0;
      blink_cnt <= 6'h00;
      row_base <= '0;
    end else if (line_tick) begin
      case (vphase)
        VP_ROWS, VP_ADJ: begin
          if (frame_done) begin
            vphase <= VP_ROWS;
            rcnt <= 5'h00;
            adj_cnt <= 5'h00;
            row <= 7'h00;
            field <= ilace & ~field;
            blink_cnt <= blink_cnt + 6'h01;
            row_base <= {start_hi, start_lo};
          end else if (vphase == VP_ADJ) begin
            adj_cnt <= adj_cnt + 5'h01;
          end else if (row_last) begin
            rcnt <= 5'h00;
            if (row == vtotal) begin
              vphase <= VP_ADJ;
            end else begin
              row <= row + 7'h01;
              row_base <= crt_add(row_base, hdisp);
            end
          end else begin
            rcnt <= rcnt + 5'h01;
          end
        end
        default: vphase <= VP_ROWS;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // vertical sync with half-raster shift in odd interlaced fields
  logic [4:0] vs_left;
  logic vs_raw;
  logic half_mode;
  logic [4:0] vsw_n;

  assign half_mode = ilace & field;
  assign vsw_n = (sync_width[7:VSW_LSB] == 4'h0) ? VSW_ZERO_RASTERS
               : {1'b0, sync_width[7:VSW_LSB]};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vs_left <= 5'h00;
      vs_raw <= 1'b0;
      vsync_out <= 1'b0;
    end else if (char_en && hcnt == 8'h00) begin
      if (vphase == VP_ROWS && rcnt == 5'h00 && row == vsync_pos) begin
        vs_left <= vsw_n - 5'h01;
        vs_raw <= 1'b1;
        if (!half_mode) vsync_out <= 1'b1;
      end else if (vs_left != 5'h00) begin
        vs_left <= vs_left - 5'h01;
      end else begin
        vs_raw <= 1'b0;
        if (!half_mode) vsync_out <= 1'b0;
      end
    end else if (char_en && half_pt && half_mode) begin
      vsync_out <= vs_raw;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // display enable, cursor, address outputs
  logic de_raw;
  logic cur_raw;
  logic blink_on;
  logic [1:0] cur_mode;

  assign cur_mode = cur_first[BLINK_LSB+1:BLINK_LSB];
  always_comb begin
    blink_on = 1'b1;
    case (cur_mode)
      CUR_STEADY: blink_on = 1'b1;
      CUR_HIDDEN: blink_on = 1'b0;
      CUR_BLINK16: blink_on = blink_cnt[BLINK16_BIT];
      CUR_BLINK32: blink_on = blink_cnt[BLINK32_BIT];
      default: blink_on = 1'b0;
    endcase
  end

  assign de_raw = (hcnt < hdisp) && (row < vdisp) && (vphase == VP_ROWS);
  assign cur_raw = (ma == {cur_hi, cur_lo}) && (vphase == VP_ROWS) && blink_on
                && (ra >= cur_first[4:0]) && (ra <= cur_last);

  crt_skew u_de_skew (
    .mclk(mclk),
    .rst_n(rst_n),
    .adv(char_en),
    .d(de_raw),
    .sel(mode_skew[DE_SKEW_LSB+1:DE_SKEW_LSB]),
    .q(display_enable_out)
  );

  crt_skew u_cur_skew (
    .mclk(mclk),
    .rst_n(rst_n),
    .adv(char_en),
    .d(cur_raw),
    .sel(mode_skew[CUR_SKEW_LSB+1:CUR_SKEW_LSB]),
    .q(cursor_out)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_address_out <= '0;
      row_select_out <= '0;
    end else if (char_en) begin
      refresh_address_out <= ma;
      row_select_out <= ra;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic [4:0] hs_chars;
  logic [3:0] hsw_seen;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hs_chars <= 5'h00;
      hsw_seen <= 4'h0;
    end else if (char_en && hcnt == hsync_pos) begin
      hs_chars <= 5'h01;
      hsw_seen <= sync_width[3:0];
    end else if (char_en && hsync_out) begin
      hs_chars <= hs_chars + 5'h01;
    end
  end

  sequence s_pen_edge;
    !pen_s ##1 pen_s;
  endsequence
  sequence s_row_wrap;
    line_tick && vphase == VP_ROWS && !isv && rcnt == max_raster && !frame_done;
  endsequence

  a_hsync_width: assert property ($fell(hsync_out) && sync_width[3:0] == hsw_seen
    |-> hs_chars == {1'b0, hsw_seen} + 5'h01)
    else $error("hsync width differs from programmed width");
  a_line_wrap: assert property (line_tick |=> hcnt == 8'h00 ##1 !char_en)
    else $error("character counter did not wrap at total");
  a_raster_wrap: assert property (s_row_wrap |=> rcnt == 5'h00)
    else $error("raster counter did not wrap");
  a_de_off: assert property (mode_skew[DE_SKEW_LSB+1:DE_SKEW_LSB] == SKEW_OFF && char_en
    |=> !display_enable_out)
    else $error("display enable not suppressed");
  a_cursor_off: assert property (mode_skew[CUR_SKEW_LSB+1:CUR_SKEW_LSB] == SKEW_OFF && char_en
    |=> !cursor_out)
    else $error("cursor output not stopped");
  a_pen_capture: assert property (s_pen_edge |=> {pen_hi, pen_lo} == $past(ma))
    else $error("pen capture missed address");
  a_cursor_match: assert property (cur_raw |-> cur_mode != CUR_HIDDEN
    && ma == {cur_hi, cur_lo} && ra <= cur_last)
    else $error("cursor raised away from its position");
  a_addr_step: assert property (char_en && !line_end |=> ma == $past(ma) + 14'h0001)
    else $error("refresh address did not step");
  a_frame_start: assert property (line_tick && frame_done
    |=> row_base == {start_hi, start_lo} && row == 7'h00)
    else $error("frame did not restart at start address");

endmodule : crt_timing_top
`default_nettype wire

// file: crt_host_model.sv
// Purpose: host processor model driving the indexed register bus
// Assumes: pins change at the falling edge of mclk
// Notes: enable held six cycles each phase, above the four recommended
`timescale 1ns/1ps
`default_nettype none
module crt_host_model import crt_pkg::*; (
  input wire logic mclk,
  output logic cs_n,
  output logic rs,
  output logic rw,
  output logic en,
  output logic [7:0] d,
  input wire logic [7:0] d_out,
  input wire logic d_oe
);
  initial begin
    cs_n = 1'b1;
    rs = 1'b0;
    rw = 1'b1;
    en = 1'b0;
    d = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one bus cycle; the read value is taken before enable drops
  task automatic cyc(input logic sel, input logic rd, input logic [7:0] v,
                     output logic [7:0] got);
    @(negedge mclk);
    cs_n <= 1'b0;
    rs <= sel;
    rw <= rd;
    d <= v;
    en <= 1'b1;
    repeat (6) @(negedge mclk);
    // a read seen without the data enable counts as unknown data
    got = (rd && !d_oe) ? 8'hxx : d_out;
    en <= 1'b0;
    repeat (6) @(negedge mclk);
    cs_n <= 1'b1;
    // released data shows the inverse so stale values never look valid
    d <= ~v;
  endtask : cyc
  // index first, then the data location
  task automatic wr_reg(input logic [4:0] idx, input logic [7:0] v);
    logic [7:0] g;
    cyc(1'b0, 1'b0, {3'h0, idx}, g);
    cyc(1'b1, 1'b0, v, g);
  endtask : wr_reg
  task automatic rd_reg(input logic [4:0] idx, output logic [7:0] v);
    logic [7:0] g;
    cyc(1'b0, 1'b0, {3'h0, idx}, g);
    cyc(1'b1, 1'b1, 8'h00, v);
  endtask : rd_reg
endmodule : crt_host_model
`default_nettype wire

// file: crt_raster_timing_controller_tb.sv
// Purpose: self-checking bench for the raster timing controller
// Assumes: 4 ns clock, character every 50 mclk cycles
// Notes: timings are measured in mclk cycles at the outputs
`timescale 1ns/1ps
`default_nettype none
module crt_raster_timing_controller_tb import crt_pkg::*;;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic pen = 1'b0;
  logic cs_n, rs, rw, en, d_oe, hs, vs, de, cur;
  logic [7:0] d_in, d_out;
  logic [ADDR_W-1:0] ma;
  logic [RAS_W-1:0] ra;
  int n_mismatch = 0;
  int n_checks = 0;
  localparam int CH = 50;
  localparam int RP = 10 * CH; // raster: htotal 9 plus one
  always #2 mclk = ~mclk;
  crt_host_model host (.mclk(mclk), .cs_n(cs_n), .rs(rs), .rw(rw), .en(en), .d(d_in),
    .d_out(d_out), .d_oe(d_oe));
  crt_timing_top uut (.mclk(mclk), .resetn(resetn), .bus_cs_n(cs_n), .bus_rs(rs),
    .bus_rw(rw), .bus_en(en), .bus_d_in(d_in), .bus_d_out(d_out), .bus_d_oe(d_oe),
    .pen_strobe_in(pen), .hsync_out(hs), .vsync_out(vs), .display_enable_out(de),
    .cursor_out(cur), .refresh_address_out(ma), .row_select_out(ra));
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  function automatic logic pick(input int s);
    case (s)
      0: pick = hs;
      1: pick = vs;
      2: pick = de;
      default: pick = cur;
    endcase
  endfunction : pick
  // bounded wait for a level; a run-out is a mismatch
  task automatic until_lvl(input int s, input logic lvl, output int n);
    n = 0;
    while (pick(s) !== lvl && n < 40000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 40000) begin
      n_mismatch++;
      $display("Error wait on output %0d expected %0b seen %0b", s, lvl, ~lvl);
      close_out();
    end
  endtask : until_lvl
  task automatic meas(input int s, output int hi, output int per);
    int n;
    int lo;
    until_lvl(s, 1'b0, n);
    until_lvl(s, 1'b1, n);
    until_lvl(s, 1'b0, hi);
    until_lvl(s, 1'b1, lo);
    per = hi + lo;
  endtask : meas
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] v;
    host.rd_reg(IDX_CUR_LO, v);
    chk("cursor low reset", 8'h00, v);
    host.wr_reg(IDX_CUR_LO, 8'ha5);
    host.rd_reg(IDX_CUR_LO, v);
    chk("cursor low", 8'ha5, v);
    host.wr_reg(IDX_CUR_HI, 8'hff);
    host.rd_reg(IDX_CUR_HI, v);
    chk("cursor high", 8'h3f, v);
    host.wr_reg(IDX_START_HI, 8'hff);
    host.rd_reg(IDX_START_HI, v);
    chk("start high", 8'h3f, v);
    host.wr_reg(IDX_PEN_HI, 8'hff);
    host.rd_reg(IDX_PEN_HI, v);
    chk("pen high read only", 8'h00, v);
    $display("register test done");
  endtask : t_regs
  // small raster: 10 chars, 6 shown, 2 rasters per row, vt plus one rows
  task automatic t_timing(input logic [7:0] sw, input logic [7:0] vt, input int vw);
    int hi;
    int per;
    host.wr_reg(IDX_HTOTAL, 8'h09);
    host.wr_reg(IDX_HDISP, 8'h06);
    host.wr_reg(IDX_HSYNC_POS, 8'h07);
    host.wr_reg(IDX_SYNC_WIDTH, sw);
    host.wr_reg(IDX_VTOTAL, vt);
    host.wr_reg(IDX_VADJ, 8'h00);
    host.wr_reg(IDX_VDISP, 8'h02);
    host.wr_reg(IDX_VSYNC_POS, 8'h02);
    host.wr_reg(IDX_MODE_SKEW, 8'h0c);
    host.wr_reg(IDX_MAX_RASTER, 8'h01);
    meas(0, hi, per);
    chk("hsync width", 2 * CH, hi);
    chk("line period", RP, per);
    meas(2, hi, per);
    chk("enable width", 6 * CH, hi);
    meas(1, hi, per);
    chk("vsync width", vw * RP, hi);
    chk("frame period", (vt + 1) * 2 * RP, per);
    $display("timing test done");
  endtask : t_timing
  // cursor at row 2, char 2, raster 0; enable and cursor one character late
  task automatic t_cursor();
    int n;
    int hi;
    int per;
    host.wr_reg(IDX_CUR_HI, 8'h3f);
    host.wr_reg(IDX_CUR_LO, 8'h0e);
    host.wr_reg(IDX_CUR_FIRST, 8'h00);
    host.wr_reg(IDX_CUR_LAST, 8'h00);
    host.wr_reg(IDX_MODE_SKEW, 8'h50);
    until_lvl(1, 1'b0, n);
    until_lvl(1, 1'b1, n);
    chk("row start address", 14'h3f0c, ma);
    chk("row select", 0, ra);
    until_lvl(3, 1'b1, n);
    chk("cursor delay", 3 * CH, n);
    until_lvl(3, 1'b0, hi);
    chk("cursor width", CH, hi);
    until_lvl(2, 1'b1, n);
    until_lvl(0, 1'b1, n);
    chk("enable to hsync", 6 * CH, n);
    // odd fields move vsync by half a raster, so periods alternate
    host.wr_reg(IDX_MODE_SKEW, 8'h01);
    meas(1, hi, per);
    chk("interlace vsync width", 2 * RP, hi);
    chk("vsync half shift", RP / 2, (per > 8 * RP) ? per - 8 * RP : 8 * RP - per);
    $display("cursor test done");
  endtask : t_cursor
  task automatic t_off();
    int k;
    int seen;
    seen = 0;
    host.wr_reg(IDX_CUR_FIRST, 8'h00);
    host.wr_reg(IDX_CUR_LAST, 8'h01);
    host.wr_reg(IDX_MODE_SKEW, 8'hf0);
    repeat (4 * CH) @(negedge mclk);
    // a little over one whole frame of the last timing set
    for (k = 0; k < 22 * RP; k++) begin
      @(negedge mclk);
      seen = seen | {30'h0, cur, de};
    end
    chk("enable and cursor suppressed", 0, seen);
    $display("suppress test done");
  endtask : t_off
  // strobe while row 2 shows its second character
  task automatic t_pen();
    logic [7:0] v;
    int n;
    until_lvl(1, 1'b0, n);
    until_lvl(1, 1'b1, n);
    @(negedge mclk);
    pen <= 1'b1;
    repeat (10) @(negedge mclk);
    pen <= 1'b0;
    host.rd_reg(IDX_PEN_HI, v);
    chk("pen high top bits", 8'h00, v & 8'hc0);
    chk("pen high", 8'h3f, v);
    host.rd_reg(IDX_PEN_LO, v);
    chk("pen low", 8'h0d, v);
    $display("pen test done");
  endtask : t_pen
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge mclk);
    resetn <= 1'b1;
    repeat (6) @(negedge mclk);
    t_regs();
    t_timing(8'h22, 8'h03, 2);
    t_cursor();
    // zero width field stands for sixteen rasters
    t_timing(8'h02, 8'h09, 16);
    t_off();
    t_pen();
    close_out();
  end
endmodule : crt_raster_timing_controller_tb
`default_nettype wire
